// [dps_map.svh]
// Purpose: Timing counts, reset values and widths for the reset sequencer
// Assumes: sys_clk at 25 MHz, 40 ns period
// Notes:   Least waits round up, longest times round down
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

// Clock period in ns
`define DPS_CLK_PERIOD_NS 40
// Self-initialization interval in us (longest)
`define DPS_T_INIT_US 150
// Reset pulse, release to select, fall to select, in ns (least)
`define DPS_T_RP_NS 200
`define DPS_T_RH_NS 200
`define DPS_T_RPH_NS 400

// Device must finish init inside the interval: round down
`define DPS_DEV_INIT_CYC ((`DPS_T_INIT_US * 1000) / `DPS_CLK_PERIOD_NS)
// Host waits at least the interval: round up
`define DPS_HOST_INIT_CYC \
  ((`DPS_T_INIT_US * 1000 + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
`define DPS_RP_CYC \
  ((`DPS_T_RP_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
`define DPS_RH_CYC \
  ((`DPS_T_RH_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
`define DPS_RPH_CYC \
  ((`DPS_T_RPH_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
// Host wait after release covers both release and fall-to-select limits
`define DPS_RH_WAIT_CYC \
  ((`DPS_RPH_CYC - `DPS_RP_CYC) > `DPS_RH_CYC ? \
   (`DPS_RPH_CYC - `DPS_RP_CYC) : `DPS_RH_CYC)
// Device recovery after reset, shorter than host wait minus sync delay
`define DPS_DEV_RECOV_CYC (`DPS_RH_CYC - 3)

// Timer width, refresh divider, default config word
`define DPS_TMR_W 12
`define DPS_REF_DIV_CYC 16
`define DPS_CFG_W 16
`define DPS_CFG_DEFAULT 16'h0001

`endif

// [dps_pkg.sv]
// Purpose: Types shared by both ends of the reset sequencer
// Assumes: Included after dps_map.svh
// Notes:   Codes are fixed so waveforms read the same across tools
package dps_pkg;

  // Device operating states
  typedef enum logic [2:0] {
    DS_OFF     = 3'b000,
    DS_RESET   = 3'b001,
    DS_INIT    = 3'b010,
    DS_RECOVER = 3'b011,
    DS_STANDBY = 3'b100,
    DS_ACTIVE  = 3'b101,
    DS_HSLEEP  = 3'b110,
    DS_DPD     = 3'b111
  } dps_dev_state_t;

  // Host sequencing states
  typedef enum logic [2:0] {
    HS_START     = 3'b000,
    HS_RST_LOW   = 3'b001,
    HS_RST_WAIT  = 3'b010,
    HS_INIT_WAIT = 3'b011,
    HS_IDLE      = 3'b100,
    HS_XFER      = 3'b101
  } dps_host_state_t;

endpackage

// [dps_if.sv]
// Purpose: Pins between host controller and memory device
// Assumes: Both ends on sys_clk; device treats the pins as asynchronous
// Notes:   Both pins are host-driven, one direction only
`timescale 1ns/10ps
interface dps_if;
  logic cs_n;      // Chip select, active low
  logic mem_rst_n; // Hardware reset pin, active low

  // Host drives both pins
  modport host (output cs_n, output mem_rst_n);
  // Device only listens
  modport dev  (input cs_n, input mem_rst_n);
endinterface

// [dps_timer.sv]
// Purpose: Loadable down counter flagging expiry of a wait
// Assumes: load_val is at least one
// Notes:   done rises exactly load_val edges after the load edge
`timescale 1ns/10ps
module dps_timer #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Load request
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Expiry level
  output logic              done
);

  logic [W-1:0] cnt;      // Cycles remaining
  logic [W-1:0] next_cnt; // Next count
  logic         next_done;

  // Load wins over counting; stop at zero
  always_comb begin
    if (load) begin
      next_cnt = load_val;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end else begin
      next_cnt = cnt;
    end
    next_done = (next_cnt == '0);
  end

  // Register count and flag
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt  <= '0;
      done <= 1'b1;
    end else begin
      cnt  <= next_cnt;
      done <= next_done;
    end
  end

endmodule

// [dps_device.sv]
// Purpose: Power-up and hardware-reset sequencing of a self-refreshing
//          memory device: init interval, refresh, low-power exit
// Assumes: Pins and supply_ok are asynchronous and are synchronised here
// Notes:   Every wait is counted in whole sys_clk cycles
`timescale 1ns/10ps
`include "dps_map.svh"
module dps_device #(
  parameter int INIT_CYC = `DPS_DEV_INIT_CYC, // Init interval cycles
  parameter int REF_DIV  = `DPS_REF_DIV_CYC,  // Normal refresh spacing
  parameter int ROW_W    = 8                  // Refresh row counter width
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // Pins from the host
  dps_if.dev                            link,
  // Supply sensor and low-power requests
  input  wire logic                     supply_ok,
  input  wire logic                     hs_req,
  input  wire logic                     dpd_req,
  // Configuration write
  input  wire logic                     cfg_wr,
  input  wire logic [`DPS_CFG_W-1:0]    cfg_wdata,
  // Status towards the core
  output logic                          ready,
  output logic                          access_start,
  output logic                          access_end,
  output logic                          array_valid,
  output logic                          refresh_pulse,
  output logic [ROW_W-1:0]              refresh_row,
  output logic [`DPS_CFG_W-1:0]         cfg,
  output dps_pkg::dps_dev_state_t       state
);
  import dps_pkg::*;

  localparam int TW = `DPS_TMR_W;
  localparam int DW = $clog2(REF_DIV + 1);

  // Synchroniser stages: bit 2 supply, bit 1 reset pin, bit 0 select
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       cs_prev;      // Select of previous cycle, for edges
  logic       sup_s;
  logic       pin_rst_n_s;
  logic       cs_n_s;
  logic       cs_fall;
  logic       cs_rise;

  // Sequencer state
  dps_dev_state_t    next_state;
  logic              pend_init;      // Power-up init still owed
  logic              next_pend_init;
  logic              tmr_load;
  logic [TW-1:0]     tmr_val;
  logic              tmr_done;
  logic              next_ready;
  logic              next_acc_start;
  logic              next_acc_end;
  logic              next_valid;
  logic [`DPS_CFG_W-1:0] next_cfg;

  // Refresh engine
  logic [DW-1:0]     div_cnt;
  logic [DW-1:0]     next_div_cnt;
  logic              next_ref_pulse;
  logic [ROW_W-1:0]  next_row;

  // Two flops per asynchronous input; only sync2 is read by logic
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          sync1[gi] <= (gi == 0) ? 1'b1 : 1'b0;
          sync2[gi] <= (gi == 0) ? 1'b1 : 1'b0;
        end else begin
          sync1[gi] <= (gi == 0) ? link.cs_n :
                       (gi == 1) ? link.mem_rst_n : supply_ok;
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  assign sup_s       = sync2[2];
  assign pin_rst_n_s = sync2[1];
  assign cs_n_s      = sync2[0];
  assign cs_fall     = cs_prev & ~cs_n_s;
  assign cs_rise     = ~cs_prev & cs_n_s;

  // Shared wait timer for init interval and reset recovery
  dps_timer #(.W(TW)) u_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // Next state: supply loss first, then reset pin, then normal flow
  always_comb begin
    next_state     = state;
    next_pend_init = pend_init;
    tmr_load       = 1'b0;
    tmr_val        = '0;
    if (!sup_s) begin
      // Below supply minimum: everything lost, init owed again
      next_state     = DS_OFF;
      next_pend_init = 1'b1;
    end else if (!pin_rst_n_s) begin
      // Any state, sleep and power-down included, drops here
      next_state = DS_RESET;
      // Exit from low power begins on the falling pin
    end else begin
      case (state)
        DS_OFF, DS_RESET: begin
          // Init starts only once the pin is high
          if (pend_init) begin
            next_state = DS_INIT;
            tmr_load   = 1'b1;
            tmr_val    = TW'(INIT_CYC);
          end else begin
            next_state = DS_RECOVER;
            tmr_load   = 1'b1;
            tmr_val    = TW'(`DPS_DEV_RECOV_CYC);
          end
        end
        DS_INIT: begin
          // Timer expiry ends the not-ready span
          if (tmr_done) begin
            next_state     = DS_STANDBY;
            next_pend_init = 1'b0;
          end
        end
        DS_RECOVER: begin
          if (tmr_done) begin
            next_state = DS_STANDBY;
          end
        end
        DS_STANDBY: begin
          // Select takes priority over low-power entry
          if (cs_fall) begin
            next_state = DS_ACTIVE;
          end else if (dpd_req) begin
            next_state = DS_DPD;
          end else if (hs_req) begin
            next_state = DS_HSLEEP;
          end
        end
        DS_ACTIVE: begin
          if (cs_rise) begin
            next_state = DS_STANDBY;
          end
        end
        DS_HSLEEP, DS_DPD: begin
          // Only a reset or supply loss leaves these here
          next_state = state;
        end
        default: begin
          next_state = DS_OFF;
        end
      endcase
    end
  end

  // Outputs, config and validity derived from the transition
  always_comb begin
    // Select edges before ready are simply dropped
    next_ready     = (next_state == DS_STANDBY) ||
                     (next_state == DS_ACTIVE);
    next_acc_start = (state == DS_STANDBY) &&
                     (next_state == DS_ACTIVE);
    next_acc_end   = (state == DS_ACTIVE) && (next_state == DS_STANDBY);
    next_cfg       = cfg;
    next_valid     = array_valid;
    if ((next_state == DS_RESET) || (next_state == DS_OFF)) begin
      // Defaults back, array contents untrusted
      next_cfg   = `DPS_CFG_DEFAULT;
      next_valid = 1'b0;
    end else if (next_state == DS_DPD) begin
      // Power-down keeps no array data
      next_valid = 1'b0;
    end else if ((state == DS_INIT) && (next_state == DS_STANDBY)) begin
      next_valid = 1'b1;
    end else if (cfg_wr && (state == DS_STANDBY)) begin
      // Config only changes while idle and ready
      next_cfg = cfg_wdata;
    end
  end

  // Refresh: every cycle during init, divided rate when running
  always_comb begin
    next_div_cnt   = div_cnt;
    next_ref_pulse = 1'b0;
    next_row       = refresh_row;
    case (next_state)
      DS_INIT: begin
        // Init sweep refreshes back to back
        next_ref_pulse = 1'b1;
        next_div_cnt   = '0;
      end
      DS_RECOVER, DS_STANDBY, DS_ACTIVE, DS_HSLEEP: begin
        // Self-refresh runs again once the pin is high
        if (div_cnt == DW'(REF_DIV - 1)) begin
          next_div_cnt   = '0;
          next_ref_pulse = 1'b1;
        end else begin
          next_div_cnt = div_cnt + DW'(1);
        end
      end
      default: begin
        // Reset, off and power-down: no refresh at all
        next_div_cnt = '0;
      end
    endcase
    if ((next_state == DS_RESET) || (next_state == DS_OFF)) begin
      // Row pointer restarts, so some rows may go stale
      next_row = '0;
    end else if (next_ref_pulse) begin
      next_row = refresh_row + ROW_W'(1);
    end
  end

  // Register all state; outputs come straight from these flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state         <= DS_OFF;
      pend_init     <= 1'b1;
      cs_prev       <= 1'b1;
      ready         <= 1'b0;
      access_start  <= 1'b0;
      access_end    <= 1'b0;
      array_valid   <= 1'b0;
      cfg           <= `DPS_CFG_DEFAULT;
      div_cnt       <= '0;
      refresh_pulse <= 1'b0;
      refresh_row   <= '0;
    end else begin
      state         <= next_state;
      pend_init     <= next_pend_init;
      cs_prev       <= cs_n_s;
      ready         <= next_ready;
      access_start  <= next_acc_start;
      access_end    <= next_acc_end;
      array_valid   <= next_valid;
      cfg           <= next_cfg;
      div_cnt       <= next_div_cnt;
      refresh_pulse <= next_ref_pulse;
      refresh_row   <= next_row;
    end
  end

endmodule

// [dps_host.sv]
// Purpose: Host side sequencing of the memory reset pin and select
// Assumes: Device on the same board clocked independently of our pins
// Notes:   Every transfer is a select-low window of xfer_len + 1 cycles
`timescale 1ns/10ps
`include "dps_map.svh"
module dps_host #(
  parameter int INIT_CYC = `DPS_HOST_INIT_CYC, // Power-up wait cycles
  parameter int RP_CYC   = `DPS_RP_CYC,        // Reset low cycles
  parameter int RH_CYC   = `DPS_RH_WAIT_CYC    // Release to select
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // Pins to the device
  dps_if.host                       link,
  // User requests
  input  wire logic                 reset_req,
  input  wire logic                 xfer_req,
  input  wire logic [7:0]           xfer_len,
  // User status
  output logic                      ready,
  output logic                      busy,
  output logic                      xfer_done,
  output logic                      data_lost,
  output dps_pkg::dps_host_state_t  state
);
  import dps_pkg::*;

  localparam int TW = `DPS_TMR_W;

  dps_host_state_t next_state;
  logic            pwrup;        // Power-up wait still to be served
  logic            next_pwrup;
  logic            tmr_load;
  logic [TW-1:0]   tmr_val;
  logic            tmr_done;
  logic            cs_n_q;       // Select pin flop
  logic            rst_n_q;      // Reset pin flop
  logic            next_cs_n;
  logic            next_rst_n;
  logic            next_done;
  logic            next_lost;

  // Shared wait timer
  dps_timer #(.W(TW)) u_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // Sequencer: pin levels are decided from the next state
  always_comb begin
    next_state = state;
    next_pwrup = pwrup;
    tmr_load   = 1'b0;
    tmr_val    = '0;
    next_done  = 1'b0;
    next_lost  = data_lost;
    case (state)
      HS_START: begin
        next_state = HS_RST_LOW;
        tmr_load   = 1'b1;
        tmr_val    = TW'(RP_CYC);
      end
      HS_RST_LOW: begin
        if (tmr_done) begin
          next_state = HS_RST_WAIT;
          tmr_load   = 1'b1;
          // Also covers the fall-to-select minimum
          tmr_val    = TW'(RH_CYC);
        end
      end
      HS_RST_WAIT: begin
        // No access until recovery is over
        if (tmr_done && pwrup) begin
          next_state = HS_INIT_WAIT;
          tmr_load   = 1'b1;
          tmr_val    = TW'(INIT_CYC);
        end else if (tmr_done) begin
          next_state = HS_IDLE;
        end
      end
      HS_INIT_WAIT: begin
        // Select held high, no access, for the whole init span
        if (tmr_done) begin
          next_state = HS_IDLE;
          next_pwrup = 1'b0;
        end
      end
      HS_IDLE: begin
        // Reset request wins over a transfer in the same cycle
        if (reset_req) begin
          next_state = HS_START;
          next_lost  = 1'b1;
        end else if (xfer_req && (xfer_len != 8'h00)) begin
          next_state = HS_XFER;
          tmr_load   = 1'b1;
          tmr_val    = TW'(xfer_len);
        end
      end
      HS_XFER: begin
        if (tmr_done) begin
          next_state = HS_IDLE;
          next_done  = 1'b1;
        end
      end
      default: begin
        next_state = HS_START;
      end
    endcase
    // A transfer request clears the lost flag, data reload assumed
    if ((state == HS_IDLE) && !reset_req && xfer_req) begin
      next_lost = 1'b0;
    end
    next_cs_n  = (next_state != HS_XFER);
    next_rst_n = (next_state != HS_START) && (next_state != HS_RST_LOW);
  end

  // Register state and pins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state     <= HS_START;
      pwrup     <= 1'b1;
      cs_n_q    <= 1'b1;
      rst_n_q   <= 1'b0;
      ready     <= 1'b0;
      busy      <= 1'b1;
      xfer_done <= 1'b0;
      data_lost <= 1'b1;
    end else begin
      state     <= next_state;
      pwrup     <= next_pwrup;
      cs_n_q    <= next_cs_n;
      rst_n_q   <= next_rst_n;
      ready     <= (next_state == HS_IDLE);
      busy      <= (next_state != HS_IDLE);
      xfer_done <= next_done;
      data_lost <= next_lost;
    end
  end

  assign link.cs_n      = cs_n_q;
  assign link.mem_rst_n = rst_n_q;

endmodule

// [dps_chk_sva.sv]
// Purpose: Pin timing and device status checks on the main link
// Assumes: Sampled on sys_clk; pins come from host flops
// Notes:   Device answers lag pins by its two-flop synchroniser
`timescale 1ns/10ps
module dps_chk #(
  parameter int INIT_CYC = 20 // Device init cycles
) (
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  // Pins
  input wire logic                    cs_n,
  input wire logic                    mem_rst_n,
  // Device status
  input wire logic                    access_start,
  input wire logic                    array_valid,
  input wire logic                    refresh_pulse,
  input wire logic [7:0]              refresh_row,
  input wire dps_pkg::dps_dev_state_t state
);
  import dps_pkg::*;
  // Slack covers the synchroniser and state flop
  localparam int INIT_MAX = INIT_CYC + 6;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_RST_PULSE:
    assert property ($fell(mem_rst_n) |-> (!mem_rst_n)[*5])
    else $error("reset pulse too short");
  AST_REL_WAIT:
    assert property ($rose(mem_rst_n) |-> cs_n[*5])
    else $error("select too soon after release");
  AST_FALL_SEL:
    assert property ($fell(mem_rst_n) |-> cs_n[*8] ##1 cs_n[*2])
    else $error("select too soon after reset fall");
  AST_PIN_RESET:
    assert property ($fell(mem_rst_n) |-> ##[1:4]
      state inside {DS_RESET, DS_OFF})
    else $error("pin low did not reach reset");
  AST_PIN_HOLD:
    assert property ((!mem_rst_n)[*5] |-> state != DS_INIT)
    else $error("init began with pin low");
  AST_REF_HALT:
    assert property ((state == DS_RESET)[*3] |->
      !refresh_pulse && !array_valid)
    else $error("refresh or valid during reset");
  AST_ROW_CLR:
    assert property ((state == DS_RESET)[*3] |-> refresh_row == 8'h00)
    else $error("row counter not cleared");
  AST_INIT_REF:
    assert property ((state == DS_INIT)[*3] |-> refresh_pulse)
    else $error("no refresh during init");
  AST_INIT_END:
    assert property ($rose(state == DS_INIT) |-> ##[1:INIT_MAX]
      state != DS_INIT)
    else $error("init overran");
  AST_INIT_EXIT:
    assert property ($fell(state == DS_INIT) |->
      state inside {DS_STANDBY, DS_RESET, DS_OFF})
    else $error("init left to wrong state");
  AST_NO_START:
    assert property (access_start |-> $past(state) == DS_STANDBY)
    else $error("access accepted while not ready");
  AST_REF_BACK:
    assert property ($rose(mem_rst_n) |-> ##[1:40] refresh_pulse)
    else $error("refresh did not resume");
  // Host keeps select high while the pin is low
  AST_NO_SEL_RST:
    assert property (!mem_rst_n |-> cs_n)
    else $error("select while reset pin low");
  // Host keeps select high for the whole init span
  AST_NO_SEL_INIT:
    assert property (state == DS_INIT |-> cs_n)
    else $error("select during init interval");
endmodule

// [dram_powerup_reset_seq_tb.sv]
// Purpose: Bench for host and device reset sequencing
// Assumes: Short init count on both ends, main supply held good
// Notes:   A second device faces a bench driver that breaks host timing
`timescale 1ns/10ps
module dram_powerup_reset_seq_tb;
  import dps_pkg::*;
  localparam int INIT_CYC = 20; // Shortened so the run stays brief
  // Clock, reset and user controls
  logic           sys_clk, rst_n, supply_ok, b_supply, b_cs_n, b_rst_n;
  logic           hs_req, dpd_req, cfg_wr, reset_req, xfer_req;
  logic [15:0]    cfg_wdata, cfg;
  logic [7:0]     xfer_len, refresh_row;
  // Device and host outputs
  logic           d_ready, access_start, access_end, array_valid;
  logic           refresh_pulse, b_ready, b_start;
  logic           h_ready, busy, xfer_done, data_lost;
  dps_dev_state_t d_state, b_state;
  // Bench counters
  int             n_fail, n_checks, cycles, b_starts;

  dps_if dps_if_i ();
  dps_if dps_if_b ();
  // Rule-breaking driver owns the second link
  assign dps_if_b.cs_n = b_cs_n;
  assign dps_if_b.mem_rst_n = b_rst_n;

  dps_host #(.INIT_CYC(INIT_CYC)) dps_host_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(dps_if_i.host),
    .reset_req(reset_req), .xfer_req(xfer_req), .xfer_len(xfer_len),
    .ready(h_ready), .busy(busy), .xfer_done(xfer_done),
    .data_lost(data_lost), .state());
  dps_device #(.INIT_CYC(INIT_CYC)) dps_device_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(dps_if_i.dev),
    .supply_ok(supply_ok), .hs_req(hs_req), .dpd_req(dpd_req),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .ready(d_ready),
    .access_start(access_start), .access_end(access_end),
    .array_valid(array_valid), .refresh_pulse(refresh_pulse),
    .refresh_row(refresh_row), .cfg(cfg), .state(d_state));
  // Second device: low-power and config inputs tied off
  dps_device #(.INIT_CYC(INIT_CYC)) dps_device_b_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(dps_if_b.dev),
    .supply_ok(b_supply), .hs_req(1'b0), .dpd_req(1'b0),
    .cfg_wr(1'b0), .cfg_wdata(16'h0000), .ready(b_ready),
    .access_start(b_start), .access_end(), .array_valid(),
    .refresh_pulse(), .refresh_row(), .cfg(), .state(b_state));
  dps_chk #(.INIT_CYC(INIT_CYC)) dps_chk_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(dps_if_i.cs_n),
    .mem_rst_n(dps_if_i.mem_rst_n), .access_start(access_start),
    .array_valid(array_valid), .refresh_pulse(refresh_pulse),
    .refresh_row(refresh_row), .state(d_state));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Hang ceiling, and starts seen on the second link
  always @(posedge sys_clk) begin
    cycles++;
    if (b_start === 1'b1) b_starts++;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Step past edges so inputs change 1 ns after them
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_rdy(input int max);
    for (int i = 0; i < max && h_ready !== 1'b1; i++) tick(1);
  endtask
  task automatic wait_dev(input dps_dev_state_t s, input int max);
    for (int i = 0; i < max && d_state !== s; i++) tick(1);
  endtask
  // One select window; count device starts during it
  task automatic host_xfer(input int exp_st);
    int st;
    st = 0;
    xfer_len = 8'h08;
    xfer_req = 1'b1;
    tick(1);
    xfer_req = 1'b0;
    for (int i = 0; i < 40 && xfer_done !== 1'b1; i++) begin
      st += int'(access_start === 1'b1);
      tick(1);
    end
    // Window end pulse stands one cycle, seen as the loop leaves
    check(16'(xfer_done), 16'h0001);
    check(16'(busy), 16'h0000);
    tick(3);
    check(16'(st), 16'(exp_st));
    check(16'(access_end), 16'(exp_st));
    check(16'(data_lost), 16'h0000);
  endtask
  // Pin reset from the host, then look inside the reset
  task automatic host_reset();
    reset_req = 1'b1;
    tick(1);
    reset_req = 1'b0;
    check(16'(data_lost), 16'h0001);
    wait_dev(DS_RESET, 10);
    tick(2);
    check(cfg, 16'h0001);
    check(16'(refresh_row), 16'h0000);
    check(16'(array_valid), 16'h0000);
    check(16'(d_ready), 16'h0000);
    wait_rdy(100);
    check(16'(d_state), 16'(DS_STANDBY));
    for (int i = 0; i < 40 && refresh_pulse !== 1'b1; i++) tick(1);
    check(16'(refresh_pulse), 16'h0001);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_n, hs_req, dpd_req, cfg_wr, reset_req, xfer_req} = 6'h00;
    {supply_ok, b_supply, b_cs_n, b_rst_n} = 4'he;
    cfg_wdata = 16'h0000;
    xfer_len = 8'h00;
    {n_fail, n_checks, cycles, b_starts} = '0;
    tick(5);
    rst_n = 1'b1;
    // Power-up: host holds the pin low, then waits out init
    tick(3);
    check(16'(d_state === DS_INIT), 16'h0000);
    check(16'(dps_if_i.cs_n), 16'h0001);
    wait_rdy(200);
    check(16'(d_state), 16'(DS_STANDBY));
    check(16'(d_ready), 16'h0001);
    check(16'(array_valid), 16'h0001);
    check(cfg, 16'h0001);
    $display("power-up test done");
    host_xfer(1);
    $display("transfer test done");
    // Config write, hybrid sleep, select ignored, then pin reset
    cfg_wdata = 16'h00a5;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    tick(1);
    check(cfg, 16'h00a5);
    hs_req = 1'b1;
    wait_dev(DS_HSLEEP, 10);
    hs_req = 1'b0;
    host_xfer(0);
    host_reset();
    $display("hybrid sleep test done");
    dpd_req = 1'b1;
    wait_dev(DS_DPD, 10);
    dpd_req = 1'b0;
    host_reset();
    $display("deep power-down test done");
    // Bad host: select with pin low and during init
    b_cs_n = 1'b0;
    tick(4);
    b_cs_n = 1'b1;
    check(16'(b_state === DS_INIT), 16'h0000);
    b_rst_n = 1'b1;
    for (int i = 0; i < 8 && b_state !== DS_INIT; i++) tick(1);
    check(16'(b_state), 16'(DS_INIT));
    b_cs_n = 1'b0;
    tick(4);
    b_cs_n = 1'b1;
    check(16'(b_ready), 16'h0000);
    for (int i = 0; i < 40 && b_state !== DS_STANDBY; i++) tick(1);
    check(16'(b_ready), 16'h0001);
    check(16'(b_starts), 16'h0000);
    b_cs_n = 1'b0;
    tick(6);
    b_cs_n = 1'b1;
    tick(2);
    check(16'(b_starts), 16'h0001);
    $display("bad host test done");
    // Supply loss on the second device: off, then full init again
    b_supply = 1'b0;
    tick(4);
    check(16'(b_state), 16'(DS_OFF));
    check(16'(b_ready), 16'h0000);
    b_supply = 1'b1;
    for (int i = 0; i < 8 && b_state !== DS_INIT; i++) tick(1);
    check(16'(b_state), 16'(DS_INIT));
    for (int i = 0; i < 40 && b_state !== DS_STANDBY; i++) tick(1);
    check(16'(b_ready), 16'h0001);
    $display("supply loss test done");
    report_and_stop();
  end
endmodule
